// file: verilog/exec_pkg.sv
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int BUS_AW = 8;
  localparam int PHASE_W = 2;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam int WATCHDOG_W = 8;
  localparam int PRESC_W = 8;
  localparam logic [7:0] WATCHDOG_CLEARED = 8'h00;
  localparam logic [7:0] PRESC_WRAP = 8'hff;
  localparam logic [7:0] PRESC_CLEARED = 8'h00;
  // Opcodes: full words, or mask/match pairs
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] MASK_FD = 14'h3f00;
  localparam logic [13:0] MATCH_ROTATE = 14'h0c00;
  localparam logic [13:0] MATCH_FILE_SUB = 14'h0200;
  localparam logic [13:0] MASK_LIT = 14'h3e00;
  localparam logic [13:0] MATCH_LIT_SUB = 14'h3c00;
  localparam int DEST_BIT = 7;
  // Bus map
  localparam logic [7:0] ADDR_FILE_TOP = 8'h7f;
  localparam logic [7:0] ADDR_ACC = 8'h80;
  localparam logic [7:0] ADDR_STATUS = 8'h81;
  localparam logic [7:0] ADDR_STACK_PTR = 8'h82;
  localparam logic [7:0] ADDR_WATCHDOG = 8'h83;
  // Status layout
  localparam int ST_C = 0;
  localparam int ST_HC = 1;
  localparam int ST_Z = 2;
  localparam int ST_LOWPWR_N = 3;
  localparam int ST_EXPIRY_N = 4;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] STATUS_WMASK = 8'h07;
  typedef enum logic [1:0] {
    ALU_SUB = 2'b01,
    ALU_RRC = 2'b10
  } alu_op_t;
endpackage

// file: verilog/sub_rot_alu.sv
`timescale 1ns/10ps
`default_nettype none
module sub_rot_alu (
  input wire exec_pkg::alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] w,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic half_carry_out,
  output logic zero_out
);
  logic [8:0] diff;
  logic [4:0] low;
  always_comb begin
    // Two's complement: a + ~w + 1, carry out is the no-borrow flag
    diff = {1'b0, a} + {1'b0, ~w} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
    result = diff[7:0];
    carry_out = diff[8];
    half_carry_out = low[4];
    if (op == exec_pkg::ALU_RRC) begin
      result = {carry_in, a[7:1]};
      carry_out = a[0];
      half_carry_out = 1'b0;
    end
    zero_out = (result == 8'h00);
  end
endmodule
`default_nettype wire

// file: verilog/cpu_instr_subset_exec.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module cpu_instr_subset_exec #(
  parameter int STACK_DEPTH = 8,
  parameter int FILE_DEPTH = 128
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [13:0] instr_word,
  input wire logic instr_valid,
  input wire logic stack_push,
  input wire logic [12:0] push_addr,
  input wire logic wake_pin,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic instr_ready,
  output logic icycle_last,
  output logic flush,
  output logic [12:0] pc,
  output logic [7:0] acc,
  output logic watchdog_expiry_flag_n,
  output logic low_power_flag_n,
  output logic sleeping,
  output logic osc_run,
  output logic [7:0] watchdog_counter
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  // ---------------------------------------------------------------
  // Wake pin synchroniser
  // ---------------------------------------------------------------
  logic wake_meta_q, wake_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_meta_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_pin;
      wake_q <= wake_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Decode and execute
  // ---------------------------------------------------------------
  logic [1:0] phase_q, phase_d;
  logic last_q, last_d;
  logic take;
  logic is_sleep, is_return, is_rotate, is_file_sub, is_lit_sub;
  logic [6:0] faddr;
  logic dest_file;
  logic [7:0] file_rd;
  logic [7:0] status_q, status_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] alu_a, alu_res;
  logic alu_c, alu_hc, alu_z;
  exec_pkg::alu_op_t alu_op;
  logic [7:0] file_q [FILE_DEPTH];
  logic [SP_W-1:0] sp_q, sp_d;
  logic [12:0] stack_q [STACK_DEPTH];
  logic [12:0] stack_head;
  logic [12:0] pc_q, pc_d;
  logic sleep_q, sleep_d;
  logic osc_q, osc_d;
  logic flush_q, flush_d;
  logic ready_q, ready_d;
  logic [7:0] wdog_q, wdog_d;
  logic [7:0] presc_q, presc_d;
  logic [7:0] rdata_q, rdata_d;
  logic file_we;
  logic [7:0] file_wdata;
  logic [6:0] file_waddr;

  assign take = last_q && instr_valid && ready_q;
  assign faddr = instr_word[exec_pkg::FADDR_W-1:0];
  assign dest_file = instr_word[exec_pkg::DEST_BIT];
  assign is_sleep = take && (instr_word == exec_pkg::OP_SLEEP);
  assign is_return = take && (instr_word == exec_pkg::OP_RETURN);
  assign is_rotate = take && ((instr_word & exec_pkg::MASK_FD) == exec_pkg::MATCH_ROTATE);
  assign is_file_sub = take && ((instr_word & exec_pkg::MASK_FD) == exec_pkg::MATCH_FILE_SUB);
  assign is_lit_sub = take && ((instr_word & exec_pkg::MASK_LIT) == exec_pkg::MATCH_LIT_SUB);
  assign file_rd = file_q[faddr];
  assign stack_head = stack_q[sp_q - SP_W'(1)];
  assign alu_op = is_rotate ? exec_pkg::ALU_RRC : exec_pkg::ALU_SUB;
  assign alu_a = is_lit_sub ? instr_word[7:0] : file_rd;

  sub_rot_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .w(acc_q),
    .carry_in(status_q[exec_pkg::ST_C]),
    .result(alu_res),
    .carry_out(alu_c),
    .half_carry_out(alu_hc),
    .zero_out(alu_z)
  );

  // ---------------------------------------------------------------
  // Instruction cycle divider
  // ---------------------------------------------------------------
  // Halts while asleep, standing in for the stopped oscillator
  always_comb begin
    phase_d = phase_q;
    if (!sleep_q) begin
      phase_d = phase_q + 2'h1;
    end
    last_d = !sleep_d && (phase_d == exec_pkg::PHASE_LAST);
  end

  // ---------------------------------------------------------------
  // Core state
  // ---------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    status_d = status_q;
    pc_d = pc_q;
    sp_d = sp_q;
    sleep_d = sleep_q;
    flush_d = flush_q;
    file_we = 1'b0;
    file_waddr = faddr;
    file_wdata = alu_res;
    if (last_q && flush_q) begin
      flush_d = 1'b0;
    end
    if (take) begin
      pc_d = pc_q + 13'h0001;
    end
    if (is_sleep) begin
      status_d[exec_pkg::ST_LOWPWR_N] = 1'b0;
      status_d[exec_pkg::ST_EXPIRY_N] = 1'b1;
      sleep_d = 1'b1;
    end
    if (is_return) begin
      pc_d = stack_head;
      sp_d = sp_q - SP_W'(1);
      flush_d = 1'b1;
    end else if (stack_push) begin
      sp_d = sp_q + SP_W'(1);
    end
    if (is_rotate || is_file_sub) begin
      if (dest_file) begin
        file_we = 1'b1;
      end else begin
        acc_d = alu_res;
      end
      status_d[exec_pkg::ST_C] = alu_c;
    end
    if (is_lit_sub) begin
      acc_d = alu_res;
      status_d[exec_pkg::ST_C] = alu_c;
    end
    if (is_file_sub || is_lit_sub) begin
      status_d[exec_pkg::ST_HC] = alu_hc;
      status_d[exec_pkg::ST_Z] = alu_z;
    end
    if (sleep_q && wake_q) begin
      sleep_d = 1'b0;
    end
    // Bus writes lose to an instruction committing in the same clock
    if (bus_wr && !take) begin
      if (bus_addr <= exec_pkg::ADDR_FILE_TOP) begin
        file_we = 1'b1;
        file_waddr = bus_addr[6:0];
        file_wdata = bus_wdata;
      end else if (bus_addr == exec_pkg::ADDR_ACC) begin
        acc_d = bus_wdata;
      end else if (bus_addr == exec_pkg::ADDR_STATUS) begin
        // Power flags are read-only to software
        status_d = (status_q & ~exec_pkg::STATUS_WMASK) | (bus_wdata & exec_pkg::STATUS_WMASK);
      end
    end
    ready_d = !sleep_d && !flush_d;
    osc_d = !sleep_d;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 2'h0;
      last_q <= 1'b0;
      acc_q <= 8'h00;
      status_q <= exec_pkg::STATUS_RESET;
      pc_q <= 13'h0000;
      sp_q <= '0;
      sleep_q <= 1'b0;
      osc_q <= 1'b1;
      flush_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      last_q <= last_d;
      acc_q <= acc_d;
      status_q <= status_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      sleep_q <= sleep_d;
      osc_q <= osc_d;
      flush_q <= flush_d;
      ready_q <= ready_d;
    end
  end

  // ---------------------------------------------------------------
  // Storage: file registers and return stack
  // ---------------------------------------------------------------
  // Stack wraps silently on overflow, like a circular buffer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_q[i] <= 8'h00;
      end
      for (int j = 0; j < STACK_DEPTH; j++) begin
        stack_q[j] <= 13'h0000;
      end
    end else begin
      if (file_we) begin
        file_q[file_waddr] <= file_wdata;
      end
      if (stack_push && !is_return) begin
        stack_q[sp_q] <= push_addr;
      end
    end
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  always_comb begin
    wdog_d = wdog_q;
    presc_d = presc_q;
    if (last_q) begin
      presc_d = presc_q + 8'h01;
      if (presc_q == exec_pkg::PRESC_WRAP) begin
        wdog_d = wdog_q + 8'h01;
      end
    end
    if (is_sleep) begin
      wdog_d = exec_pkg::WATCHDOG_CLEARED;
      presc_d = exec_pkg::PRESC_CLEARED;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdog_q <= exec_pkg::WATCHDOG_CLEARED;
      presc_q <= exec_pkg::PRESC_CLEARED;
    end else begin
      wdog_q <= wdog_d;
      presc_q <= presc_d;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (bus_rd) begin
      if (bus_addr <= exec_pkg::ADDR_FILE_TOP) begin
        rdata_d = file_q[bus_addr[6:0]];
      end else if (bus_addr == exec_pkg::ADDR_ACC) begin
        rdata_d = acc_q;
      end else if (bus_addr == exec_pkg::ADDR_STATUS) begin
        rdata_d = status_q;
      end else if (bus_addr == exec_pkg::ADDR_STACK_PTR) begin
        rdata_d = 8'(sp_q);
      end else if (bus_addr == exec_pkg::ADDR_WATCHDOG) begin
        rdata_d = wdog_q;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign instr_ready = ready_q;
  assign icycle_last = last_q;
  assign flush = flush_q;
  assign pc = pc_q;
  assign acc = acc_q;
  assign watchdog_expiry_flag_n = status_q[exec_pkg::ST_EXPIRY_N];
  assign low_power_flag_n = status_q[exec_pkg::ST_LOWPWR_N];
  assign sleeping = sleep_q;
  assign osc_run = osc_q;
  assign watchdog_counter = wdog_q;
endmodule
`default_nettype wire

// file: tb/exec_chk.sv
`timescale 1ns/10ps
`default_nettype none
module exec_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [13:0] instr_word,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic icycle_last,
  input wire logic flush,
  input wire logic [12:0] pc,
  input wire logic [7:0] acc,
  input wire logic watchdog_expiry_flag_n,
  input wire logic low_power_flag_n,
  input wire logic sleeping,
  input wire logic osc_run,
  input wire logic [7:0] watchdog_counter
);
  // ----------
  // Decode of the taken word
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take;
  logic is_sleep;
  logic is_ret;
  logic is_lit;
  assign take = icycle_last && instr_ready && instr_valid;
  assign is_sleep = take && (instr_word == exec_pkg::OP_SLEEP);
  assign is_ret = take && (instr_word == exec_pkg::OP_RETURN);
  assign is_lit = take && ((instr_word & exec_pkg::MASK_LIT) == exec_pkg::MATCH_LIT_SUB);
  sequence flushed_cycle;
    (flush && !instr_ready) [*4];
  endsequence
  sequence resumed;
    !flush && instr_ready;
  endsequence
  a_sleep_wdog_clear: assert property (is_sleep |=> watchdog_counter == 8'h00)
    else $error("watchdog not cleared by power-down");
  a_sleep_flags: assert property (is_sleep |=> !low_power_flag_n && watchdog_expiry_flag_n)
    else $error("status flags wrong after power-down");
  a_sleep_osc_stop: assert property (is_sleep |=> sleeping && !osc_run)
    else $error("oscillator still running after power-down");
  a_osc_vs_sleep: assert property (osc_run == !sleeping)
    else $error("oscillator state disagrees with sleep state");
  a_ret_flags_kept: assert property (is_ret |=> $stable(low_power_flag_n) && $stable(acc))
    else $error("return changed state it must keep");
  a_ret_flush_len: assert property (is_ret |=> flushed_cycle ##1 resumed)
    else $error("return flush cycle length wrong");
  a_lit_sub_acc: assert property (is_lit |=> acc == $past(instr_word[7:0]) - $past(acc))
    else $error("literal subtract result wrong");
  a_pc_single_step: assert property (take && !is_ret && !is_sleep |=> pc == $past(pc) + 13'h1)
    else $error("program counter did not step by one");
  a_icycle_period: assert property (icycle_last |=> !icycle_last [*3])
    else $error("instruction cycle shorter than four clocks");
endmodule
bind cpu_instr_subset_exec exec_chk chk_u (.clk(clk), .resetn(resetn), .instr_word(instr_word),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .icycle_last(icycle_last),
  .flush(flush), .pc(pc), .acc(acc), .watchdog_expiry_flag_n(watchdog_expiry_flag_n),
  .low_power_flag_n(low_power_flag_n), .sleeping(sleeping), .osc_run(osc_run),
  .watchdog_counter(watchdog_counter));
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic instr_valid = 1'b0;
  logic stack_push = 1'b0;
  logic [12:0] push_addr = 13'h0000;
  logic wake_pin = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata, acc, watchdog_counter;
  logic instr_ready, icycle_last, flush, watchdog_expiry_flag_n, low_power_flag_n;
  logic sleeping, osc_run;
  logic [12:0] pc;
  int fails = 0;
  int checks = 0;
  always #50 clk = ~clk;
  cpu_instr_subset_exec dut_u (.clk(clk), .resetn(resetn), .instr_word(instr_word),
    .instr_valid(instr_valid), .stack_push(stack_push), .push_addr(push_addr),
    .wake_pin(wake_pin), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .instr_ready(instr_ready),
    .icycle_last(icycle_last), .flush(flush), .pc(pc), .acc(acc),
    .watchdog_expiry_flag_n(watchdog_expiry_flag_n), .low_power_flag_n(low_power_flag_n),
    .sleeping(sleeping), .osc_run(osc_run), .watchdog_counter(watchdog_counter));
  // ----------
  // Shared drivers
  // ----------
  task automatic results;
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic brd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 check(bus_rdata, e);
  endtask
  // Flags are read settled after an edge; the next edge then takes the word
  task automatic issue(input logic [13:0] w);
    int n = 0;
    @(posedge clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    #1;
    while (!(icycle_last === 1'b1 && instr_ready === 1'b1) && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    if (n >= 40) begin
      fails++;
      results();
    end
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_bus;
    brd(8'h81, 8'h18);
    bwr(8'h83, 8'h55);
    brd(8'h83, 8'h00);
    bwr(8'h90, 8'h55);
    brd(8'h90, 8'h00);
  endtask
  task automatic t_sub;
    bwr(8'h05, 8'h30);
    bwr(8'h80, 8'h10);
    issue(14'h0205);
    check(acc, 8'h20);
    brd(8'h81, 8'h1b);
    issue(14'h0285);
    check(acc, 8'h20);
    brd(8'h05, 8'h10);
    issue(14'h3c20);
    check(acc, 8'h00);
    brd(8'h81, 8'h1f);
    issue(14'h3c05);
    issue(14'h3c00);
    check(acc, 8'hfb);
    brd(8'h81, 8'h18);
  endtask
  task automatic t_rrf;
    bwr(8'h7f, 8'h81);
    bwr(8'h81, 8'h06);
    issue(14'h0c7f);
    check(acc, 8'h40);
    brd(8'h7f, 8'h81);
    brd(8'h81, 8'h1f);
    issue(14'h0cff);
    brd(8'h7f, 8'hc0);
    check(acc, 8'h40);
  endtask
  task automatic t_ret;
    @(posedge clk);
    stack_push <= 1'b1;
    push_addr <= 13'h1abc;
    @(posedge clk);
    stack_push <= 1'b0;
    issue(exec_pkg::OP_RETURN);
    check(pc, 13'h1abc);
    check({flush, instr_ready}, 2'b10);
    brd(8'h81, 8'h1f);
    issue(14'h3c01);
    check(pc, 13'h1abd);
    check(acc, 8'hc1);
  endtask
  task automatic t_sleep;
    int n = 0;
    // Let the prescaler wrap once so the clear is visible
    while (watchdog_counter !== 8'h01 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    check(watchdog_counter, 8'h01);
    issue(exec_pkg::OP_SLEEP);
    check(watchdog_counter, 8'h00);
    check({low_power_flag_n, watchdog_expiry_flag_n}, 2'b01);
    check({sleeping, osc_run, instr_ready}, 3'b100);
    brd(8'h81, 8'h12);
    repeat (20) @(posedge clk);
    #1 check({icycle_last, watchdog_counter}, 9'h000);
    @(posedge clk);
    wake_pin <= 1'b1;
    n = 0;
    while (sleeping !== 1'b0 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    wake_pin <= 1'b0;
    check({osc_run, low_power_flag_n}, 2'b10);
    issue(14'h3c00);
    check(acc, 8'h3f);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_bus();
    t_sub();
    t_rrf();
    t_ret();
    t_sleep();
    results();
  end
endmodule
`default_nettype wire
